// ==== verilog/stm_timer.sv ====
// standard 10-bit timer: compare match output, timer/counter and pwm modes
// assumes a byte register port with read data one cycle after the strobe
// Operation
// - counter high byte reads bits nine, eight
// - compare A low byte read/write, resets zero
// - compare A high byte holds bits nine, eight
// - mode 00 selects compare match output
// - clear-select low: clear on P/overflow, both flags
// - clear-select high: clear on A, A flag
// - compare mode: only A match moves pin
// - A match drives high, low, toggle, none
// - function 00 hold, 01 low, 10 high, 11 toggle
// - enable rising edge loads initial pin level
// - mode 11 behaves like compare, pin unused
// - mode 10 pwm, clear-select ignored
// - one comparator sets period, other duty
// - swap zero: P period, A duty
// - P period is 128 times code, zero 1024
// - P compares counter top three bits
// - pwm sets A and P flags separately
// - output control sets active level, function forces
// - polarity bit inverts pwm output
// - duty at or above period gives 100%
`include "stm_map.svh"
module stm_timer
   import stm_pkg::*;
#(
   parameter int CNT_WIDTH = 10
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic pinOut,
   output logic pinOe,
   output logic compareAFlag,
   output logic compareBothFlag
);
   localparam logic [CNT_WIDTH-1:0] CNT_MAX = '1;

   // period in counts for a 3-bit period code, code zero the full 1024 range
   function automatic logic [CNT_WIDTH:0] period_len(input logic [2:0] code);
      logic [CNT_WIDTH:0] len;
      len = (code == 3'h0) ? (CNT_WIDTH + 1)'(1 << CNT_WIDTH)
         : (CNT_WIDTH + 1)'(code) * (CNT_WIDTH + 1)'(`STM_PERIOD_STEP);
      return len;
   endfunction : period_len

   // period comparator looks only at the three top counter bits
   function automatic logic period_hit(input logic [CNT_WIDTH-1:0] value,
      input logic [2:0] code);
      return (code != 3'h0) && (value[CNT_WIDTH-1:CNT_WIDTH-3] == code);
   endfunction : period_hit

   // timer clock enable from the divider
   stm_tick_if tk ();

   stm_tick_div u_div (
      .clk (clk),
      .rst (rst),
      .tk (tk.source)
   );

   // software registers
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [9:0] compare_a_value;
   logic [7:0] tickDiv;
   logic [1:0] flags;
   logic [7:0] next_ctrl0;
   logic [7:0] next_ctrl1;
   logic [9:0] next_compare_a_value;
   logic [7:0] next_tickDiv;
   logic [1:0] next_flags;
   logic [7:0] next_regRdata;
   // timer state
   stm_run_t runState;
   stm_run_t next_runState;
   logic [CNT_WIDTH-1:0] counter;
   logic [CNT_WIDTH-1:0] next_counter;
   logic pinLevel;
   logic next_pinLevel;
   logic pinOutReg;
   logic next_pinOut;
   logic pinOeReg;
   logic next_pinOe;
   // decoded fields
   stm_mode_t mode;
   stm_fn_t fn;
   logic timer_enable;
   logic [2:0] period_compare_value;
   logic counter_clear_select;
   logic period_duty_swap;
   logic output_polarity;
   logic output_initial_level;
   logic matchA;
   logic matchP;
   logic overflow;
   logic stepping;
   logic [CNT_WIDTH-1:0] counterInc;
   logic clearCnt;
   logic setA;
   logic setP;
   logic [CNT_WIDTH:0] periodLen;
   logic [CNT_WIDTH:0] dutyLen;
   logic pwmActive;
   logic pwmLevel;

   // control fields decoded from the registers
   assign mode = stm_mode_t'(ctrl1[7:6]);
   assign fn = stm_fn_t'(ctrl1[5:4]);
   assign timer_enable = ctrl0[`STM_CTRL0_ENABLE];
   assign period_compare_value = ctrl0[2:0];
   assign counter_clear_select = ctrl1[`STM_CTRL1_CCLR];
   assign period_duty_swap = ctrl1[`STM_CTRL1_SWAP];
   assign output_polarity = ctrl1[`STM_CTRL1_POL];
   assign output_initial_level = ctrl1[`STM_CTRL1_OC];
   assign tk.divide = tickDiv;

   // counting step and the count one tick ahead
   always_comb
   begin
      stepping = tk.tick && (runState == STM_RUN_COUNT);
      counterInc = counter + CNT_WIDTH'(1);
   end

   // comparator events on the counting tick; the period match looks one
   // count ahead so a period lasts 128 times the code, not one tick more
   always_comb
   begin
      matchA = stepping && (counter == CNT_WIDTH'(compare_a_value));
      matchP = stepping && period_hit(counterInc, period_compare_value);
      overflow = stepping && (counter == CNT_MAX) && (period_compare_value == 3'h0);
      clearCnt = 1'b0;
      setA = 1'b0;
      setP = 1'b0;
      case (mode)
         STM_MODE_COMPARE, STM_MODE_TIMER:
         begin
            setA = matchA;
            if (counter_clear_select)
            begin
               clearCnt = matchA;
            end
            else
            begin
               clearCnt = matchP || overflow;
               setP = matchP || overflow;
            end
         end
         STM_MODE_PWM:
         begin
            setA = matchA;
            setP = matchP || overflow;
            clearCnt = period_duty_swap ? matchA : (matchP || overflow);
         end
         default:
         begin
            clearCnt = 1'b0;
         end
      endcase
   end

   // pwm period and duty from the swap bit
   always_comb
   begin
      if (!period_duty_swap)
      begin
         periodLen = period_len(period_compare_value);
         dutyLen = (CNT_WIDTH + 1)'(compare_a_value);
      end
      else
      begin
         periodLen = (CNT_WIDTH + 1)'(compare_a_value) + (CNT_WIDTH + 1)'(1);
         dutyLen = period_len(period_compare_value);
      end
      pwmActive = ((CNT_WIDTH + 1)'(counter) < dutyLen)
         || (dutyLen >= periodLen);
      pwmLevel = pwmActive ? output_initial_level : !output_initial_level;
   end

   // counter, run state and pin level
   always_comb
   begin
      next_runState = runState;
      next_counter = counter;
      next_pinLevel = pinLevel;
      case (runState)
         STM_RUN_IDLE:
         begin
            if (timer_enable)
            begin
               next_runState = STM_RUN_START;
            end
         end
         STM_RUN_START:
         begin
            next_counter = '0;
            next_pinLevel = output_initial_level;
            next_runState = timer_enable ? STM_RUN_COUNT : STM_RUN_IDLE;
         end
         STM_RUN_COUNT:
         begin
            if (!timer_enable)
            begin
               next_runState = STM_RUN_IDLE;
            end
            else if (tk.tick)
            begin
               next_counter = clearCnt ? '0 : counterInc;
            end
         end
         default:
         begin
            next_runState = STM_RUN_IDLE;
         end
      endcase
      if (mode == STM_MODE_COMPARE && setA)
      begin
         case (fn)
            STM_FN_LOW: next_pinLevel = 1'b0;
            STM_FN_HIGH: next_pinLevel = 1'b1;
            STM_FN_TOGGLE: next_pinLevel = !pinLevel;
            default: next_pinLevel = pinLevel;
         endcase
      end
   end

   // pin drive per mode
   always_comb
   begin
      next_pinOe = 1'b0;
      next_pinOut = 1'b0;
      case (mode)
         STM_MODE_COMPARE:
         begin
            next_pinOe = 1'b1;
            next_pinOut = pinLevel ^ output_polarity;
         end
         STM_MODE_PWM:
         begin
            next_pinOe = 1'b1;
            case (fn)
               STM_FN_HOLD: next_pinOut = !output_initial_level;
               STM_FN_LOW: next_pinOut = output_initial_level;
               default: next_pinOut = timer_enable ? pwmLevel : !output_initial_level;
            endcase
            next_pinOut = next_pinOut ^ output_polarity;
         end
         default:
         begin
            next_pinOe = 1'b0;
         end
      endcase
   end

   // register writes and flag updates, set wins over clear
   always_comb
   begin
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_compare_a_value = compare_a_value;
      next_tickDiv = tickDiv;
      next_flags = flags;
      next_regRdata = 8'h00;
      if (regWrite)
      begin
         case (regAddr)
            `STM_OFF_CTRL0: next_ctrl0 = regWdata;
            `STM_OFF_CTRL1: next_ctrl1 = regWdata;
            `STM_OFF_CMPA_LO: next_compare_a_value[7:0] = regWdata;
            `STM_OFF_CMPA_HI: next_compare_a_value[9:8] = regWdata[1:0];
            `STM_OFF_FLAGS: next_flags = flags & ~regWdata[1:0];
            `STM_OFF_TICK: next_tickDiv = regWdata;
            default: next_flags = next_flags;
         endcase
      end
      if (setA)
      begin
         next_flags[`STM_FLAG_A] = 1'b1;
      end
      if (setP)
      begin
         next_flags[`STM_FLAG_P] = 1'b1;
      end
      if (regRead)
      begin
         case (regAddr)
            `STM_OFF_CTRL0: next_regRdata = ctrl0;
            `STM_OFF_CTRL1: next_regRdata = ctrl1;
            `STM_OFF_CNT_LO: next_regRdata = counter[7:0];
            `STM_OFF_CNT_HI: next_regRdata = {6'h00, counter[9:8]};
            `STM_OFF_CMPA_LO: next_regRdata = compare_a_value[7:0];
            `STM_OFF_CMPA_HI: next_regRdata = {6'h00, compare_a_value[9:8]};
            `STM_OFF_FLAGS: next_regRdata = {6'h00, flags};
            `STM_OFF_TICK: next_regRdata = tickDiv;
            default: next_regRdata = 8'h00;
         endcase
      end
   end

   // register all state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl0 <= `STM_RESET_BYTE;
         ctrl1 <= `STM_RESET_BYTE;
         compare_a_value <= 10'h000;
         tickDiv <= `STM_TICK_DIV_RESET;
         flags <= 2'h0;
         regRdata <= 8'h00;
         runState <= STM_RUN_IDLE;
         counter <= '0;
         pinLevel <= 1'b0;
         pinOutReg <= 1'b0;
         pinOeReg <= 1'b0;
      end
      else
      begin
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         compare_a_value <= next_compare_a_value;
         tickDiv <= next_tickDiv;
         flags <= next_flags;
         regRdata <= next_regRdata;
         runState <= next_runState;
         counter <= next_counter;
         pinLevel <= next_pinLevel;
         pinOutReg <= next_pinOut;
         pinOeReg <= next_pinOe;
      end
   end

   // outputs straight from their flip-flops
   assign pinOut = pinOutReg;
   assign pinOe = pinOeReg;
   assign compareAFlag = flags[`STM_FLAG_A];
   assign compareBothFlag = flags[`STM_FLAG_P];
endmodule : stm_timer

// ==== common/stm_map.svh ====
// register offsets, field positions and reset values of the standard timer
// assumes a plain byte-wide register port with word-free byte offsets
`ifndef STM_MAP_SVH
`define STM_MAP_SVH
`define STM_OFF_CTRL0 4'h0
`define STM_OFF_CTRL1 4'h1
`define STM_OFF_CNT_LO 4'h2
`define STM_OFF_CNT_HI 4'h3
`define STM_OFF_CMPA_LO 4'h4
`define STM_OFF_CMPA_HI 4'h5
`define STM_OFF_FLAGS 4'h6
`define STM_OFF_TICK 4'h7
`define STM_CTRL0_ENABLE 3
`define STM_CTRL1_CCLR 0
`define STM_CTRL1_SWAP 1
`define STM_CTRL1_POL 2
`define STM_CTRL1_OC 3
`define STM_FLAG_A 0
`define STM_FLAG_P 1
`define STM_RESET_BYTE 8'h00
`define STM_TICK_DIV_RESET 8'h00
`define STM_PERIOD_STEP 11'h080
`endif

// ==== common/stm_pkg.sv ====
// types shared by the standard timer modules
// assumes the map header for all numeric constants
package stm_pkg;
   typedef enum logic [1:0] {
      STM_MODE_COMPARE = 2'h0,
      STM_MODE_CAPTURE = 2'h1,
      STM_MODE_PWM = 2'h2,
      STM_MODE_TIMER = 2'h3
   } stm_mode_t;
   typedef enum logic [1:0] {
      STM_FN_HOLD = 2'h0,
      STM_FN_LOW = 2'h1,
      STM_FN_HIGH = 2'h2,
      STM_FN_TOGGLE = 2'h3
   } stm_fn_t;
   typedef enum logic [2:0] {
      STM_RUN_IDLE = 3'b001,
      STM_RUN_START = 3'b010,
      STM_RUN_COUNT = 3'b100
   } stm_run_t;
endpackage : stm_pkg

// ==== common/stm_tick_if.sv ====
// timer clock enable carried from the divider to the timer core
// assumes one clock domain
interface stm_tick_if;
   logic [7:0] divide;
   logic tick;
   modport source (input divide, output tick);
   modport sink (output divide, input tick);
endinterface : stm_tick_if

// ==== verilog/stm_tick_div.sv ====
// one-cycle timer clock enable, one pulse every divide+1 system clocks
// assumes synchronous active-high reset on clk
`include "stm_map.svh"
module stm_tick_div
   import stm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   stm_tick_if.source tk
);
   logic [7:0] count;
   logic [7:0] next_count;
   logic tick;
   logic next_tick;

   // count down to zero then reload
   always_comb
   begin
      next_tick = (count == 8'h00);
      next_count = next_tick ? tk.divide : count - 8'h01;
   end

   // register divider state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count <= `STM_TICK_DIV_RESET;
         tick <= 1'b0;
      end
      else
      begin
         count <= next_count;
         tick <= next_tick;
      end
   end

   assign tk.tick = tick;
endmodule : stm_tick_div

// ==== tb/stm_timer_asserts.sv ====
// checker for the timer register port, flags and reset state
// assumes it is bound to stm_timer and sees only its ports
module stm_timer_asserts
   import stm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   input wire logic pinOut,
   input wire logic pinOe,
   input wire logic compareAFlag,
   input wire logic compareBothFlag
);
   timeunit 1ns;
   timeprecision 1ns;
   // one clock domain, checks paused in reset except the reset state check
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // read data bytes and their unused bits
   idle_data_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data outside its slot");
   count_high_a: assert property ($past(regRead) && $past(regAddr) == 4'h3
      |-> regRdata[7:2] == 6'h00) else $error("counter high byte spare bits set");
   cmp_high_a: assert property ($past(regRead) && $past(regAddr) == 4'h5
      |-> regRdata[7:2] == 6'h00) else $error("compare high byte spare bits set");
   low_back_a: assert property (regWrite && regAddr == 4'h4 ##1 !regWrite ##1 regRead &&
      regAddr == 4'h4 |=> regRdata == $past(regWdata, 3)) else $error("low byte lost");
   high_back_a: assert property (regWrite && regAddr == 4'h5 ##1 !regWrite ##1 regRead &&
      regAddr == 4'h5 |=> regRdata == ($past(regWdata, 3) & 8'h03))
      else $error("high byte lost");
   // sticky flags drop only on a write of one
   flag_a_hold_a: assert property ($fell(compareAFlag) |-> $past(regWrite) &&
      $past(regAddr) == 4'h6 && $past(regWdata[0])) else $error("a flag dropped");
   flag_p_hold_a: assert property ($fell(compareBothFlag) |-> $past(regWrite) &&
      $past(regAddr) == 4'h6 && $past(regWdata[1])) else $error("p flag dropped");
   reset_state_a: assert property (disable iff (1'b0) rst |=> regRdata == 8'h00 &&
      !pinOut && !pinOe && !compareAFlag && !compareBothFlag) else $error("reset state");
   // main scenarios seen
   cover property ($rose(compareAFlag));
   cover property ($rose(compareBothFlag));
   cover property ($changed(pinOut));
endmodule : stm_timer_asserts

bind stm_timer stm_timer_asserts chk (.clk(clk), .rst(rst), .regAddr(regAddr),
   .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .pinOut(pinOut), .pinOe(pinOe), .compareAFlag(compareAFlag),
   .compareBothFlag(compareBothFlag));

// ==== tb/test_standard_timer_compare_pwm.sv ====
// self-checking bench for the standard timer
// assumes the checker is bound to the timer and a fixed stimulus seed
module test_standard_timer_compare_pwm
   import stm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, regWrite, regRead, pinOut, pinOe, compareAFlag, compareBothFlag, oc;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata, r, d;
   int badCount, checkCount, n, h, v, f;
   stm_timer DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pinOut(pinOut),
      .pinOe(pinOe), .compareAFlag(compareAFlag), .compareBothFlag(compareBothFlag));
   // system clock, 40 ns period
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // next value of the stimulus shift register
   function logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nx
   // pin level after a compare A match
   function logic ep(input logic [1:0] fn, input logic o);
      return fn == 2'h0 ? o : fn == 2'h3 ? ~o : fn[1];
   endfunction : ep
   // wait clocks, sample past the edge
   task cy(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cy
   // one write strobe, driven on the edge and dropped on the next
   task wr(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= x;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   // one read strobe, data taken in the cycle after it
   task rd(input logic [3:0] a);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      d = regRdata;
   endtask : rd
   // compare and count, unknowns fail
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checkCount++;
      if (g !== e)
      begin
         badCount++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // stop, clear flags, program and start
   task cfg(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
      wr(4'h0, 8'h00);
      wr(4'h6, 8'h03);
      wr(4'h1, c1);
      wr(4'h4, a[7:0]);
      wr(4'h5, {6'h00, a[9:8]});
      wr(4'h0, c0);
   endtask : cfg
   // count high pwm clocks over one period
   task pw(input logic [7:0] c1, input logic [9:0] a, input int w, input int e);
      cfg(c1, a, 8'h09);
      cy(w + 8);
      h = 0;
      repeat (w)
      begin
         cy(1);
         h += pinOut;
      end
      chk("pwm high", e, h);
   endtask : pw
   task endOfTest();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : endOfTest
   // cut a hung run short
   initial
   begin
      repeat (30000) @(posedge clk);
      badCount++;
      endOfTest();
   end
   // main sequence
   initial
   begin
      rst = 1'b1;
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      badCount = 0;
      checkCount = 0;
      r = 8'h62;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cy(2);
      rd(4'h5);
      chk("cmp hi reset", 8'h00, d);
      repeat (8)
      begin
         r = nx(r);
         wr(4'h4, r);
         rd(4'h4);
         chk("cmp lo", r, d);
         wr(4'h5, ~r);
         rd(4'h5);
         chk("cmp hi", {6'h00, ~r[1:0]}, d);
         wr(4'h3, r);
         rd(4'h3);
         chk("cnt hi", 8'h00, d);
         rd({1'b1, r[2:0]});
         chk("unmapped", 8'h00, d);
      end
      for (f = 0; f < 4; f++)
      begin
         r = nx(r);
         v = 8 + r[3:0];
         oc = r[4];
         cfg({2'b00, f[1:0], oc, 3'b001}, 10'(v), 8'h08);
         cy(4);
         chk("pin start", oc, pinOut);
         chk("pin enable", 1, pinOe);
         for (n = 0; n < 99 && compareAFlag !== 1'b1; n++) cy(1);
         cy(3);
         chk("pin match", ep(f[1:0], oc), pinOut);
         chk("p flag", 0, compareBothFlag);
      end
      oc = pinOut;
      for (n = 0; n < 99 && pinOut === oc; n++) cy(1);
      oc = pinOut;
      for (n = 0; n < 99 && pinOut === oc; n++) cy(1);
      chk("toggle gap", v + 1, n);
      wr(4'h7, 8'h01);
      rd(4'h7);
      chk("tick div", 8'h01, d);
      cy(4);
      oc = pinOut;
      for (n = 0; n < 99 && pinOut === oc; n++) cy(1);
      oc = pinOut;
      for (n = 0; n < 99 && pinOut === oc; n++) cy(1);
      chk("slow gap", 2 * (v + 1), n);
      wr(4'h7, 8'h00);
      for (f = 0; f < 3; f++)
      begin
         cfg(8'h00, 10'(v), 8'h08 | 8'(f));
         for (n = 0; n < 1100 && compareBothFlag !== 1'b1; n++) cy(1);
         wr(4'h6, 8'h02);
         for (n = 2; n < 1100 && compareBothFlag !== 1'b1; n++) cy(1);
         chk("p period", f == 0 ? 1024 : 128 * f, n);
         chk("a flag", 1, compareAFlag);
      end
      cfg(8'h00, 10'(v), 8'h08);
      cy(600);
      rd(4'h3);
      chk("cnt hi run", 8'h02, d);
      rd(4'h2);
      chk("cnt lo run", 8'h59, d);
      // timer mode, period code below the A value
      cfg(8'hf1, 10'h0c8, 8'h09);
      for (n = 0; n < 300 && compareAFlag !== 1'b1; n++) cy(1);
      chk("oe timer", 0, pinOe);
      chk("a timer", 1, compareAFlag);
      chk("p timer", 0, compareBothFlag);
      // capture mode is not built: no flags, pin released
      cfg(8'h41, 10'(v), 8'h08);
      cy(40);
      chk("oe capture", 0, pinOe);
      chk("flags capture", 2'b00, {compareAFlag, compareBothFlag});
      r = nx(r);
      v = r[6:0] | 1;
      pw(8'ha9, 10'(v), 128, v);
      chk("pwm flags", 2'b11, {compareAFlag, compareBothFlag});
      pw(8'had, 10'(v), 128, 128 - v);
      pw(8'ha9, 10'h0c8, 128, 128);
      pw(8'h88, 10'(v), 128, 0);
      pw(8'h98, 10'(v), 128, 128);
      pw(8'haa, 10'h12b, 300, 128);
      endOfTest();
   end
endmodule : test_standard_timer_compare_pwm
